// ===== hdl/swc_pkg.sv
// package: register map, field layout and timing for system options block
package swc_pkg;
    // ========================================
    // register byte offsets on the processor register port
    localparam logic [7:0] SWC_OFS_RESET_STATUS = 8'h00;
    localparam logic [7:0] SWC_OFS_DEBUG_FORCE_RESET = 8'h01;
    localparam logic [7:0] SWC_OFS_OPTIONS_ONE = 8'h02;
    localparam logic [7:0] SWC_OFS_OPTIONS_TWO = 8'h03;
    localparam logic [7:0] SWC_OFS_PART_ID_HIGH = 8'h06;
    localparam logic [7:0] SWC_OFS_PART_ID_LOW = 8'h07;

    // ========================================
    // field positions
    localparam int SWC_FORCE_RESET_BIT = 0;
    localparam int SWC_WD_TIMEOUT_HI = 7;
    localparam int SWC_WD_TIMEOUT_LO = 6;
    localparam int SWC_STOP_ENABLE_BIT = 5;
    localparam int SWC_TWO_WIRE_BIT = 3;
    localparam int SWC_WD_CLOCK_BIT = 7;
    localparam int SWC_WD_WINDOW_BIT = 6;
    localparam int SWC_CONV_TRIG_BIT = 4;
    localparam int SWC_CLKOUT_DIV_HI = 2;
    localparam int SWC_CLKOUT_DIV_LO = 0;

    // ========================================
    // reset values and read masks
    localparam logic [7:0] SWC_OPT1_RESET = 8'hC0;
    localparam logic [7:0] SWC_OPT2_RESET = 8'h00;
    localparam logic [7:0] SWC_OPT1_MASK = 8'hE8;
    localparam logic [7:0] SWC_OPT2_MASK = 8'hD7;
    localparam logic [7:0] SWC_OPT2_ONCE_MASK = 8'hC0;
    localparam logic [7:0] SWC_READ_ZERO = 8'h00;

    // ========================================
    // watchdog service sequence and counts
    localparam logic [7:0] SWC_SERVICE_FIRST = 8'h55;
    localparam logic [7:0] SWC_SERVICE_SECOND = 8'hAA;
    localparam int SWC_WD_CNT_W = 19;
    localparam logic [1:0] SWC_WD_OFF = 2'h0;
    localparam logic [1:0] SWC_WD_SHORT = 2'h1;
    localparam logic [1:0] SWC_WD_MID = 2'h2;
    localparam logic [18:0] SWC_LPO_LIMIT_SHORT = 19'h00020;
    localparam logic [18:0] SWC_LPO_LIMIT_MID = 19'h00100;
    localparam logic [18:0] SWC_LPO_LIMIT_LONG = 19'h00400;
    localparam logic [18:0] SWC_BUS_LIMIT_SHORT = 19'h02000;
    localparam logic [18:0] SWC_BUS_LIMIT_MID = 19'h10000;
    localparam logic [18:0] SWC_BUS_LIMIT_LONG = 19'h40000;
    localparam logic [18:0] SWC_BUS_OPEN_SHORT = 19'h01800;
    localparam logic [18:0] SWC_BUS_OPEN_MID = 19'h0C000;
    localparam logic [18:0] SWC_BUS_OPEN_LONG = 19'h30000;

    // ========================================
    // time base
    localparam int SWC_CLK_PERIOD_PS = 4000;
    localparam int SWC_LPO_PERIOD_US = 1000;
    localparam int SWC_LPO_CYCLES = SWC_LPO_PERIOD_US * 1000 * 1000 / SWC_CLK_PERIOD_PS;
endpackage

// ===== hdl/swc_system_options.sv
// system options, debug force reset, identification and watchdog top
`timescale 1ns/1ns
`default_nettype none
module swc_system_options
    import swc_pkg::*;
#(
    // arbitrary part number and revision, not any real device code
    parameter logic [11:0] PART_NUMBER = 12'h5A3,
    parameter logic [3:0] REVISION = 4'h1,
    parameter int LPO_CYCLES = SWC_LPO_CYCLES
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_from_debug_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // processor events
    input wire logic stop_exec_i,
    output logic stop_grant_o,
    // converter trigger
    input wire logic converter_hw_trigger_enable_i,
    input wire logic rtc_overflow_i,
    input wire logic irq_pin_i,
    output logic converter_trigger_o,
    // pin routing and clock output
    output logic two_wire_pin_select_o,
    output logic clock_out_en_o,
    output logic clock_out_o,
    // reset requests
    output logic force_reset_o,
    output logic illegal_opcode_reset_o,
    output logic watchdog_reset_o,
    output logic system_reset_req_o
);
    // ========================================
    // parameter checks
    generate
        if (LPO_CYCLES < 2)
        begin : g_bad_lpo
            $error("LPO_CYCLES must be at least 2");
        end
    endgenerate

    localparam int LPO_W = $clog2(LPO_CYCLES);

    // ========================================
    // state
    typedef struct packed {
        logic [7:0] opt1;
        logic [7:0] opt2;
        logic opt1_locked;
        logic opt2_locked;
        logic [7:0] rdata;
        logic force_rst;
        logic ilop_rst;
        logic stop_grant;
        logic [LPO_W-1:0] lpo_cnt;
        logic lpo_tick;
        logic [2:0] clk_cnt;
        logic clk_out;
        logic clk_en;
        logic irq_s1;
        logic irq_s2;
        logic irq_s3;
        logic irq_level;
        logic conv_trig;
    } swc_state_t;

    swc_state_t st_reg;
    swc_state_t st_next;

    logic wr_debug;
    logic wr_opt1;
    logic wr_opt2;
    logic wr_srs;
    logic [7:0] part_high;
    logic [7:0] part_low;
    logic [1:0] wd_timeout_sel;
    logic wd_clock_sel;
    logic wd_window_en;
    logic stop_mode_enable;
    logic converter_trigger_select;
    logic [2:0] clock_output_divider;
    logic wd_tick;
    logic wd_rst;

    // ========================================
    // field views
    always_comb
    begin
        wd_timeout_sel = st_reg.opt1[SWC_WD_TIMEOUT_HI:SWC_WD_TIMEOUT_LO];
        stop_mode_enable = st_reg.opt1[SWC_STOP_ENABLE_BIT];
        wd_clock_sel = st_reg.opt2[SWC_WD_CLOCK_BIT];
        wd_window_en = st_reg.opt2[SWC_WD_WINDOW_BIT];
        converter_trigger_select = st_reg.opt2[SWC_CONV_TRIG_BIT];
        clock_output_divider = st_reg.opt2[SWC_CLKOUT_DIV_HI:SWC_CLKOUT_DIV_LO];
        part_high = {REVISION, PART_NUMBER[11:8]};
        part_low = PART_NUMBER[7:0];
    end

    // ========================================
    // address decode
    always_comb
    begin
        // user-program writes to the debug register never decode
        wr_debug = reg_wr_i && reg_from_debug_i
            && (reg_addr_i == SWC_OFS_DEBUG_FORCE_RESET);
        wr_opt1 = reg_wr_i && (reg_addr_i == SWC_OFS_OPTIONS_ONE);
        wr_opt2 = reg_wr_i && (reg_addr_i == SWC_OFS_OPTIONS_TWO);
        wr_srs = reg_wr_i && (reg_addr_i == SWC_OFS_RESET_STATUS);
    end

    // ========================================
    // next state
    always_comb
    begin
        st_next = st_reg;
        st_next.force_rst = 1'b0;
        st_next.ilop_rst = 1'b0;
        st_next.stop_grant = 1'b0;

        // write-once options one
        if (wr_opt1 && !st_reg.opt1_locked)
        begin
            st_next.opt1 = reg_wdata_i & SWC_OPT1_MASK;
            st_next.opt1_locked = 1'b1;
        end

        // options two: once bits lock, trigger and divider stay writable
        if (wr_opt2)
        begin
            if (!st_reg.opt2_locked)
            begin
                st_next.opt2 = reg_wdata_i & SWC_OPT2_MASK;
                st_next.opt2_locked = 1'b1;
            end
            else
            begin
                st_next.opt2 = (st_reg.opt2 & SWC_OPT2_ONCE_MASK)
                    | (reg_wdata_i & SWC_OPT2_MASK & ~SWC_OPT2_ONCE_MASK);
            end
        end

        // debug force reset
        if (wr_debug && reg_wdata_i[SWC_FORCE_RESET_BIT])
        begin
            st_next.force_rst = 1'b1;
        end

        // stop instruction
        if (stop_exec_i)
        begin
            if (stop_mode_enable)
            begin
                st_next.stop_grant = 1'b1;
            end
            else
            begin
                st_next.ilop_rst = 1'b1;
            end
        end

        // read data, registered one cycle after the strobe
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                SWC_OFS_DEBUG_FORCE_RESET: st_next.rdata = SWC_READ_ZERO;
                SWC_OFS_OPTIONS_ONE: st_next.rdata = st_reg.opt1;
                SWC_OFS_OPTIONS_TWO: st_next.rdata = st_reg.opt2;
                SWC_OFS_PART_ID_HIGH: st_next.rdata = part_high;
                SWC_OFS_PART_ID_LOW: st_next.rdata = part_low;
                default: st_next.rdata = SWC_READ_ZERO;
            endcase
        end

        // 1 kHz time base as a one-cycle enable
        st_next.lpo_tick = 1'b0;
        if (st_reg.lpo_cnt == LPO_W'(LPO_CYCLES - 1))
        begin
            st_next.lpo_cnt = '0;
            st_next.lpo_tick = 1'b1;
        end
        else
        begin
            st_next.lpo_cnt = st_reg.lpo_cnt + 1'b1;
        end

        // clock output: toggle every divider-value cycles
        if (clock_output_divider == 3'h0)
        begin
            st_next.clk_cnt = 3'h0;
            st_next.clk_out = 1'b0;
            st_next.clk_en = 1'b0;
        end
        else
        begin
            st_next.clk_en = 1'b1;
            if (st_reg.clk_cnt >= clock_output_divider - 3'h1)
            begin
                st_next.clk_cnt = 3'h0;
                st_next.clk_out = ~st_reg.clk_out;
            end
            else
            begin
                st_next.clk_cnt = st_reg.clk_cnt + 3'h1;
            end
        end

        // interrupt pin: three stages, change counts when stages two and three agree
        st_next.irq_s1 = irq_pin_i;
        st_next.irq_s2 = st_reg.irq_s1;
        st_next.irq_s3 = st_reg.irq_s2;
        if (st_reg.irq_s2 == st_reg.irq_s3)
        begin
            st_next.irq_level = st_reg.irq_s3;
        end

        // converter hardware trigger source
        if (!converter_hw_trigger_enable_i)
        begin
            st_next.conv_trig = 1'b0;
        end
        else if (converter_trigger_select)
        begin
            st_next.conv_trig = st_reg.irq_level;
        end
        else
        begin
            st_next.conv_trig = rtc_overflow_i;
        end
    end

    // ========================================
    // state register
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_reg <= '0;
            st_reg.opt1 <= SWC_OPT1_RESET;
            st_reg.opt2 <= SWC_OPT2_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ========================================
    // watchdog
    assign wd_tick = wd_clock_sel ? 1'b1 : st_reg.lpo_tick;

    swc_watchdog u_watchdog (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .tick_i(wd_tick),
        .timeout_sel_i(wd_timeout_sel),
        .bus_clock_i(wd_clock_sel),
        .window_i(wd_window_en),
        .srs_wr_i(wr_srs),
        .srs_wdata_i(reg_wdata_i),
        .wd_reset_o(wd_rst)
    );

    // ========================================
    // outputs
    assign reg_rdata_o = st_reg.rdata;
    assign stop_grant_o = st_reg.stop_grant;
    assign converter_trigger_o = st_reg.conv_trig;
    assign two_wire_pin_select_o = st_reg.opt1[SWC_TWO_WIRE_BIT];
    assign clock_out_en_o = st_reg.clk_en;
    assign clock_out_o = st_reg.clk_out;
    assign force_reset_o = st_reg.force_rst;
    assign illegal_opcode_reset_o = st_reg.ilop_rst;
    assign watchdog_reset_o = wd_rst;
    // the reset controller is outside; it pulls resetn_i in answer
    assign system_reset_req_o = st_reg.force_rst | st_reg.ilop_rst | wd_rst;
endmodule
`default_nettype wire

// ===== hdl/swc_watchdog.sv
// watchdog counter with service sequence and windowed mode
`timescale 1ns/1ns
`default_nettype none
module swc_watchdog
    import swc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // configuration
    input wire logic tick_i,
    input wire logic [1:0] timeout_sel_i,
    input wire logic bus_clock_i,
    input wire logic window_i,
    // service writes
    input wire logic srs_wr_i,
    input wire logic [7:0] srs_wdata_i,
    // reset request
    output logic wd_reset_o
);
    typedef struct packed {
        logic [SWC_WD_CNT_W-1:0] cnt;
        logic got_first;
        logic rst;
    } swc_wd_state_t;

    swc_wd_state_t st_reg;
    swc_wd_state_t st_next;
    logic [SWC_WD_CNT_W-1:0] limit;
    logic [SWC_WD_CNT_W-1:0] open_at;
    logic enabled;
    logic early;

    // ========================================
    // period select
    always_comb
    begin
        enabled = (timeout_sel_i != SWC_WD_OFF);
        case (timeout_sel_i)
            SWC_WD_SHORT:
            begin
                limit = bus_clock_i ? SWC_BUS_LIMIT_SHORT : SWC_LPO_LIMIT_SHORT;
                open_at = SWC_BUS_OPEN_SHORT;
            end
            SWC_WD_MID:
            begin
                limit = bus_clock_i ? SWC_BUS_LIMIT_MID : SWC_LPO_LIMIT_MID;
                open_at = SWC_BUS_OPEN_MID;
            end
            default:
            begin
                limit = bus_clock_i ? SWC_BUS_LIMIT_LONG : SWC_LPO_LIMIT_LONG;
                open_at = SWC_BUS_OPEN_LONG;
            end
        endcase
        // window only defined for the bus clock source
        early = window_i && bus_clock_i && (st_reg.cnt < open_at);
    end

    // ========================================
    // counter and service
    always_comb
    begin
        st_next = st_reg;
        st_next.rst = 1'b0;
        if (!enabled)
        begin
            st_next.cnt = '0;
            st_next.got_first = 1'b0;
        end
        else if (srs_wr_i)
        begin
            if (early)
            begin
                st_next.rst = 1'b1;
                st_next.cnt = '0;
            end
            else if (srs_wdata_i == SWC_SERVICE_FIRST)
            begin
                st_next.got_first = 1'b1;
            end
            else if (srs_wdata_i == SWC_SERVICE_SECOND)
            begin
                if (st_reg.got_first)
                begin
                    st_next.cnt = '0;
                end
                st_next.got_first = 1'b0;
            end
            else
            begin
                st_next.rst = 1'b1;
                st_next.cnt = '0;
                st_next.got_first = 1'b0;
            end
        end
        else if (tick_i)
        begin
            // at or above, so a period shortened late still fires
            if (st_reg.cnt >= limit - 1'b1)
            begin
                st_next.rst = 1'b1;
                st_next.cnt = '0;
            end
            else
            begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign wd_reset_o = st_reg.rst;
endmodule
`default_nettype wire

// ===== verif/swc_debug_host.sv
// debug host model: background-debug writes to the force reset register
`timescale 1ns/1ns
`default_nettype none
module swc_debug_host
(
    // clock
    input wire logic core_clk_i,
    // command from the bench
    input wire logic req_i,
    input wire logic [7:0] data_i,
    // debug write toward the register port
    output logic wr_o,
    output logic [7:0] wdata_o
);
    initial wr_o = 1'b0;
    initial wdata_o = 8'h00;
    always @(posedge core_clk_i)
    begin
        wr_o <= req_i;
        // released data is not held, so stale values cannot pass for fresh ones
        wdata_o <= req_i ? data_i : ~wdata_o;
    end
endmodule
`default_nettype wire

// ===== verif/swc_system_options_properties.sv
// assertion checker watching the system options block ports
`timescale 1ns/1ns
`default_nettype none
module swc_system_options_properties
    import swc_pkg::*;
#(
    parameter logic [11:0] PART_NUMBER = 12'h5A3, // arbitrary value, no real part
    parameter logic [3:0] REVISION = 4'h1
)
(
    // clock, reset and register port
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_from_debug_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // events and outputs
    input wire logic stop_exec_i,
    input wire logic stop_grant_o,
    input wire logic converter_hw_trigger_enable_i,
    input wire logic converter_trigger_o,
    input wire logic clock_out_en_o,
    input wire logic clock_out_o,
    input wire logic force_reset_o,
    input wire logic illegal_opcode_reset_o,
    input wire logic watchdog_reset_o,
    input wire logic system_reset_req_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic dbg_hit = reg_addr_i == SWC_OFS_DEBUG_FORCE_RESET;
    // ========================================
    // assertions
    user_write_dropped_a: assert property (reg_wr_i && dbg_hit && !reg_from_debug_i |=> !force_reset_o)
        else $error("user write caused a force reset");
    debug_force_a: assert property (reg_wr_i && dbg_hit && reg_from_debug_i && reg_wdata_i[0]
        |=> force_reset_o ##1 !force_reset_o) else $error("debug force reset pulse wrong");
    force_read_zero_a: assert property (reg_rd_i && dbg_hit |=> reg_rdata_o == SWC_READ_ZERO)
        else $error("force reset register read nonzero");
    reset_merge_a: assert property (system_reset_req_o == (force_reset_o ||
        illegal_opcode_reset_o || watchdog_reset_o)) else $error("reset request merge wrong");
    stop_answer_a: assert property (stop_exec_i |=> stop_grant_o != illegal_opcode_reset_o)
        else $error("stop got no single answer");
    id_low_a: assert property (reg_rd_i && reg_addr_i == SWC_OFS_PART_ID_LOW
        |=> reg_rdata_o == PART_NUMBER[7:0]) else $error("identity low wrong");
    id_high_a: assert property (reg_rd_i && reg_addr_i == SWC_OFS_PART_ID_HIGH
        |=> reg_rdata_o == {REVISION, PART_NUMBER[11:8]}) else $error("identity high wrong");
    trigger_idle_a: assert property (!converter_hw_trigger_enable_i [*2] |-> !converter_trigger_o)
        else $error("trigger while disabled");
    clock_out_off_a: assert property (!clock_out_en_o [*2] |-> !clock_out_o)
        else $error("clock output active while disabled");
    read_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
endmodule
`default_nettype wire

// ===== verif/swc_system_options_tb.sv
// self-checking bench for the system options block
`timescale 1ns/1ns
`default_nettype none
module swc_system_options_tb;
    import swc_pkg::*;
    localparam logic [11:0] PART_NUMBER = 12'h5A3; // arbitrary value, no real part
    localparam logic [3:0] REVISION = 4'h1;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic tb_wr = 1'b0, reg_rd_i = 1'b0, host_req = 1'b0, stop_exec_i = 1'b0;
    logic trig_en = 1'b0, irq_pin_i = 1'b0, rtc_ov = 1'b0, host_wr;
    logic [7:0] tb_addr = 8'h00, tb_wdata = 8'h00, host_data = 8'h00, host_wdata, o1, o2;
    logic [7:0] reg_rdata_o;
    logic stop_grant_o, converter_trigger_o, two_wire_pin_select_o, clock_out_en_o;
    logic clock_out_o, force_reset_o, illegal_opcode_reset_o, watchdog_reset_o;
    logic system_reset_req_o;
    logic [31:0] seed = 32'h806B;
    int failures = 0, n_tests = 0, n;
    always #2 core_clk_i = ~core_clk_i;
    // ========================================
    // device and debug host
    swc_debug_host u_swc_debug_host (.core_clk_i(core_clk_i), .req_i(host_req),
        .data_i(host_data), .wr_o(host_wr), .wdata_o(host_wdata));
    swc_system_options #(.PART_NUMBER(PART_NUMBER), .REVISION(REVISION), .LPO_CYCLES(8))
    u_swc_system_options (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(host_wr ? SWC_OFS_DEBUG_FORCE_RESET : tb_addr), .reg_wr_i(tb_wr | host_wr),
        .reg_rd_i(reg_rd_i), .reg_from_debug_i(host_wr),
        .reg_wdata_i(host_wr ? host_wdata : tb_wdata), .reg_rdata_o(reg_rdata_o),
        .stop_exec_i(stop_exec_i), .stop_grant_o(stop_grant_o),
        .converter_hw_trigger_enable_i(trig_en), .rtc_overflow_i(rtc_ov), .irq_pin_i(irq_pin_i),
        .converter_trigger_o(converter_trigger_o), .two_wire_pin_select_o(two_wire_pin_select_o),
        .clock_out_en_o(clock_out_en_o), .clock_out_o(clock_out_o),
        .force_reset_o(force_reset_o), .illegal_opcode_reset_o(illegal_opcode_reset_o),
        .watchdog_reset_o(watchdog_reset_o), .system_reset_req_o(system_reset_req_o));
    // ========================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic conclude();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        tb_wr <= 1'b1;
        tb_addr <= a;
        tb_wdata <= d;
        @(posedge core_clk_i);
        tb_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        tb_addr <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(reg_rdata_o, e);
    endtask
    task automatic do_reset();
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
    endtask
    // bounded wait for a watchdog reset pulse; n counts the cycles waited
    task automatic wait_wd(input int lim);
        n = 0;
        while (watchdog_reset_o !== 1'b1)
        begin
            tick();
            n++;
            if (n > lim)
            begin
                failures++;
                conclude();
            end
        end
    endtask
    // cycles until the clock output changes level
    task automatic half();
        logic v;
        v = clock_out_o;
        n = 0;
        while (clock_out_o === v && n < 20)
        begin
            tick();
            n++;
        end
    endtask
    // ========================================
    // main sequence
    initial
    begin
        do_reset();
        rdc(SWC_OFS_OPTIONS_ONE, SWC_OPT1_RESET);
        rdc(SWC_OFS_DEBUG_FORCE_RESET, SWC_READ_ZERO);
        rdc(SWC_OFS_OPTIONS_TWO, SWC_OPT2_RESET);
        rdc(SWC_OFS_PART_ID_LOW, PART_NUMBER[7:0]);
        rdc(SWC_OFS_PART_ID_HIGH, {REVISION, PART_NUMBER[11:8]});
        wr(SWC_OFS_DEBUG_FORCE_RESET, 8'hFF);
        check(force_reset_o, 1'b0);
        @(posedge core_clk_i);
        host_req <= 1'b1;
        host_data <= 8'h01;
        @(posedge core_clk_i);
        host_req <= 1'b0;
        tick();
        check({force_reset_o, system_reset_req_o}, 2'h3);
        rdc(SWC_OFS_DEBUG_FORCE_RESET, SWC_READ_ZERO);
        $display("debug and identity test done");
        // round 0 serviced bus watchdog, 1 window breach, 2 low-power tick source (every 8 cycles here), 3 disabled
        for (int r = 0; r < 4; r++)
        begin
            seed = xs(seed);
            o1 = (seed[7:0] & 8'h1F) | (r == 3 ? 8'h00 : 8'h40) | (r == 1 ? 8'h20 : 8'h00);
            o2 = {r != 2, r == 1, seed[12], r == 1, seed[13], r == 2 ? 3'h0 : seed[10:8] | 3'h1};
            do_reset();
            trig_en <= 1'b1;
            irq_pin_i <= 1'b1;
            wr(SWC_OFS_OPTIONS_ONE, o1);
            wr(SWC_OFS_OPTIONS_ONE, ~o1);
            rdc(SWC_OFS_OPTIONS_ONE, o1 & SWC_OPT1_MASK);
            check(two_wire_pin_select_o, o1[3]);
            wr(SWC_OFS_OPTIONS_TWO, o2);
            wr(SWC_OFS_OPTIONS_TWO, o2 ^ 8'hC0);
            rdc(SWC_OFS_OPTIONS_TWO, o2 & SWC_OPT2_MASK);
            check(converter_trigger_o, r == 1);
            @(posedge core_clk_i);
            rtc_ov <= 1'b1;
            @(posedge core_clk_i);
            rtc_ov <= 1'b0;
            #1;
            check(converter_trigger_o, 1'b1);
            tick();
            check(converter_trigger_o, r == 1);
            check(clock_out_en_o, o2[2:0] != 3'h0);
            if (o2[2:0] != 3'h0)
            begin
                half();
                half();
                check(n, o2[2:0]);
            end
            @(posedge core_clk_i);
            stop_exec_i <= 1'b1;
            @(posedge core_clk_i);
            stop_exec_i <= 1'b0;
            #1;
            check({stop_grant_o, illegal_opcode_reset_o}, r == 1 ? 2'h2 : 2'h1);
            if (r == 0)
            begin
                repeat (5000) tick();
                wr(SWC_OFS_RESET_STATUS, SWC_SERVICE_FIRST);
                wr(SWC_OFS_RESET_STATUS, SWC_SERVICE_SECOND);
                wait_wd(9000);
                check(n > 8000 && n <= 8200, 1'b1);
            end
            else if (r == 1)
            begin
                wr(SWC_OFS_RESET_STATUS, SWC_SERVICE_FIRST);
                wait_wd(3);
                check(n < 3, 1'b1);
            end
            else if (r == 2)
            begin
                wait_wd(400);
                check(n >= 200 && n <= 270, 1'b1);
            end
            else
            begin
                // disabled watchdog ignores a bad service value
                wr(SWC_OFS_RESET_STATUS, 8'h12);
                n = 0;
                repeat (300)
                begin
                    tick();
                    n += (watchdog_reset_o !== 1'b0);
                end
                check(n, 0);
            end
            $display("round %0d done", r);
        end
        conclude();
    end
    initial
    begin
        #200000;
        failures++;
        conclude();
    end
endmodule
bind swc_system_options swc_system_options_properties
    #(.PART_NUMBER(PART_NUMBER), .REVISION(REVISION)) u_swc_system_options_properties
    (.core_clk_i, .resetn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_from_debug_i, .reg_wdata_i,
    .reg_rdata_o, .stop_exec_i, .stop_grant_o, .converter_hw_trigger_enable_i,
    .converter_trigger_o, .clock_out_en_o, .clock_out_o, .force_reset_o,
    .illegal_opcode_reset_o, .watchdog_reset_o, .system_reset_req_o);
`default_nettype wire
